// file: rtl/sks_ipv6_key.sv
// Overview of operation
// R1 - Port map bit set for ingress port
// R2 - Outer tag state: none, VID zero, nonzero
// R3 - Inner tag state: none, VID zero, nonzero
// R4 - Encap codes: Ethernet II/SNAP; IPv6 marker
// R5 - Carry IPv6 traffic class byte
// R6 - Carry last parsed next header
// R7 - Fragment, later fragment, authentication flags
// R8 - Hop limit class: 0, 1, 255, other
// R9 - Nine valid bits for user fields
// R10 - Outer tag from packet or port default
// R11 - Inner tag from packet or port default
// R12 - Nine user fields gated by valid bits
// R13 - Slice selector encodes slice 0, 1, 2
// R14 - Rule writer sets slice-valid to ones
// R15 - Reserved key bits driven zero
// R16 - Key exactly 232 bits wide
// R17 - User fields from slice's IPv6 set
`timescale 1ns/1ns
`default_nettype none

module sks_ipv6_key
   import sks_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire sks_reg_req_t reg_req,
   output logic [31:0] reg_rdata,
   input wire sks_pkt_t pkt_in,
   input wire logic pkt_valid,
   output logic pkt_ready,
   output sks_key_t key_out,
   output logic key_valid,
   input wire logic key_ready
);

   sks_state_t st;
   sks_state_t next_st;

   logic [9:0] udf_off;
   logic [1:0] udf_slice;
   logic [3:0] udf_field;
   logic udf_hit;
   logic tag_hit;
   logic [2:0] tag_idx;

   assign udf_off = reg_req.addr - SKS_OFF_UDF_BASE;
   assign udf_slice = udf_off[7:6];
   assign udf_field = udf_off[5:2];
   assign udf_hit = (reg_req.addr >= SKS_OFF_UDF_BASE) && (reg_req.addr <= SKS_OFF_UDF_LAST)
      && (reg_req.addr[1:0] == 2'h0) && (udf_slice < 2'(SKS_SLICES))
      && (udf_field < 4'(SKS_UDFS));
   assign tag_hit = (reg_req.addr >= SKS_OFF_PORT_TAG_BASE)
      && (reg_req.addr <= SKS_OFF_PORT_TAG_LAST) && (reg_req.addr[1:0] == 2'h0);
   assign tag_idx = reg_req.addr[4:2];

   function automatic logic [1:0] tag_state(input logic present, input logic [15:0] tag);
      logic [1:0] r;
      if (!present) begin
         r = SKS_TAG_NONE;
      end else if (tag[SKS_VID_W-1:0] == '0) begin
         r = SKS_TAG_VID0;
      end else begin
         r = SKS_TAG_VID;
      end
      return r;
   endfunction

   function automatic logic [1:0] hop_class(input logic [7:0] hl);
      logic [1:0] r;
      if (hl == SKS_HOP_VAL_ZERO) begin
         r = SKS_HOP_ZERO;
      end else if (hl == SKS_HOP_VAL_ONE) begin
         r = SKS_HOP_ONE;
      end else if (hl == SKS_HOP_VAL_MAX) begin
         r = SKS_HOP_MAX;
      end else begin
         r = SKS_HOP_OTHER;
      end
      return r;
   endfunction

   // Lowest enabled slice at or above 'from'; MSB flags a find
   function automatic logic [2:0] find_slice(input logic [2:0] mask, input logic [2:0] from);
      logic [2:0] r;
      r = '0;
      for (int i = SKS_SLICES - 1; i >= 0; i--) begin
         if (mask[i] && (3'(i) >= from)) begin
            r = {1'b1, 2'(i)};
         end
      end
      return r;
   endfunction

   function automatic sks_key_t build_key(
      input sks_pkt_t p,
      input logic [1:0] s,
      input logic [SKS_PORTS-1:0][31:0] tags,
      input logic [SKS_SLICES-1:0][SKS_UDFS-1:0][4:0] cfg
   );
      sks_key_t k;
      logic [31:0] dflt;
      logic [4:0] c;
      k = '0; // R15
      dflt = tags[p.ingress_port];
      k.ingress_port_mask = SKS_PORT_ONE << p.ingress_port; // R1
      k.outer_tag_state = tag_state(p.outer_present, p.outer_tag); // R2
      k.inner_tag_state = tag_state(p.inner_present, p.inner_tag); // R3
      k.link_layer_encap_code = p.snap ? SKS_L2_SNAP : SKS_L2_ETH2; // R4
      k.network_layer_encap_code = SKS_L3_IPV6; // R4
      k.ipv6_class_byte = p.ipv6_class_byte; // R5
      k.final_next_hdr = p.final_next_hdr; // R6
      k.frag_flag = p.frag_flag; // R7
      // A later fragment is by definition fragmented
      k.later_frag_flag = p.frag_flag & p.later_frag_flag; // R7
      k.auth_hdr_flag = p.auth_hdr_flag; // R7
      k.hop_limit_class = hop_class(p.hop_limit); // R8
      k.outer_tag = p.outer_present ? p.outer_tag : dflt[31:16]; // R10
      k.inner_tag = p.inner_present ? p.inner_tag : dflt[15:0]; // R11
      for (int f = 0; f < SKS_UDFS; f++) begin
         c = cfg[s][f]; // R17
         // Word beyond what the parser captured is not valid data
         k.user_field_valid_vec[f] = c[SKS_UDF_EN_BIT]
            && ({1'b0, c[3:0]} < p.window_len); // R9
         // Data zeroed when invalid so stale words never reach the table
         k.ipv6_user_field[f] = k.user_field_valid_vec[f] ? p.window[c[3:0]] : 16'h0000; // R12
      end
      k.search_slice_sel = s; // R13
      // Entries are only matched when the table also holds ones here
      k.slice_valid = SKS_SLICE_VALID; // R14
      return k; // R16
   endfunction

   always_comb begin
      logic [2:0] pick;
      pick = '0;
      next_st = st;
      // Read data stands one cycle only
      next_st.rdata = '0;

      if (reg_req.wr) begin
         if (reg_req.addr == SKS_OFF_CTRL) begin
            next_st.enable = reg_req.wdata[SKS_CTRL_EN_BIT];
            next_st.slice_en = reg_req.wdata[SKS_CTRL_SLICE_LSB +: 3];
         end else if (reg_req.addr == SKS_OFF_PKT_CNT) begin
            next_st.pkt_cnt = SKS_CNT_RST;
         end else if (reg_req.addr == SKS_OFF_KEY_CNT) begin
            next_st.key_cnt = SKS_CNT_RST;
         end else if (reg_req.addr == SKS_OFF_DROP_CNT) begin
            next_st.drop_cnt = SKS_CNT_RST;
         end else if (tag_hit) begin
            next_st.port_tags[tag_idx] = reg_req.wdata;
         end else if (udf_hit) begin
            next_st.udf_cfg[udf_slice][udf_field] = reg_req.wdata[4:0];
         end
      end

      if (reg_req.rd) begin
         if (reg_req.addr == SKS_OFF_CTRL) begin
            next_st.rdata[SKS_CTRL_EN_BIT] = st.enable;
            next_st.rdata[SKS_CTRL_SLICE_LSB +: 3] = st.slice_en;
         end else if (reg_req.addr == SKS_OFF_STATUS) begin
            next_st.rdata[SKS_STAT_BUSY_BIT] = (st.fsm == SKS_EMIT);
            next_st.rdata[SKS_STAT_SLICE_LSB +: 2] = st.slice;
            next_st.rdata[SKS_STAT_EN_BIT] = st.enable;
         end else if (reg_req.addr == SKS_OFF_PKT_CNT) begin
            next_st.rdata = st.pkt_cnt;
         end else if (reg_req.addr == SKS_OFF_KEY_CNT) begin
            next_st.rdata = st.key_cnt;
         end else if (reg_req.addr == SKS_OFF_DROP_CNT) begin
            next_st.rdata = st.drop_cnt;
         end else if (tag_hit) begin
            next_st.rdata = st.port_tags[tag_idx];
         end else if (udf_hit) begin
            next_st.rdata[4:0] = st.udf_cfg[udf_slice][udf_field];
         end
      end

      // Keys are built from the captured packet, so config writes mid-packet
      // affect only the slices not yet emitted
      case (st.fsm)
         SKS_IDLE: begin
            if (pkt_valid) begin
               pick = find_slice(st.slice_en, 3'h0);
               if (st.enable && pick[2]) begin
                  next_st.pkt_cnt = next_st.pkt_cnt + 32'h0000_0001;
                  next_st.pkt = pkt_in;
                  next_st.slice = pick[1:0];
                  next_st.key = build_key(pkt_in, pick[1:0], next_st.port_tags,
                     next_st.udf_cfg);
                  next_st.fsm = SKS_EMIT;
               end else begin
                  next_st.drop_cnt = next_st.drop_cnt + 32'h0000_0001;
               end
            end
         end
         SKS_EMIT: begin
            if (key_ready) begin
               next_st.key_cnt = next_st.key_cnt + 32'h0000_0001;
               pick = find_slice(st.slice_en, {1'b0, st.slice} + 3'h1);
               if (pick[2]) begin
                  next_st.slice = pick[1:0];
                  next_st.key = build_key(st.pkt, pick[1:0], next_st.port_tags,
                     next_st.udf_cfg);
               end else begin
                  next_st.fsm = SKS_IDLE;
               end
            end
         end
         default: begin
            next_st.fsm = SKS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.enable <= SKS_EN_RST;
         st.slice_en <= SKS_SLICE_EN_RST;
         st.port_tags <= {SKS_PORTS{SKS_PORT_TAG_RST}};
         st.udf_cfg <= {(SKS_SLICES * SKS_UDFS){SKS_UDF_CFG_RST}};
         st.fsm <= SKS_IDLE;
      end else begin
         st <= next_st;
      end
   end

   assign reg_rdata = st.rdata;
   assign key_out = st.key;
   assign key_valid = (st.fsm == SKS_EMIT);
   assign pkt_ready = (st.fsm == SKS_IDLE);

endmodule

`default_nettype wire

// file: rtl/sks_pkg.sv
package sks_pkg;

   // Sizes of the key and of the structures behind it
   localparam int SKS_PORTS = 8;
   localparam int SKS_SLICES = 3;
   localparam int SKS_UDFS = 9;
   localparam int SKS_WIN = 16;
   localparam int SKS_VID_W = 12;
   localparam int SKS_KEY_W = 232;

   // Register offsets (byte addresses, one word each)
   localparam logic [9:0] SKS_OFF_CTRL = 10'h000;
   localparam logic [9:0] SKS_OFF_STATUS = 10'h004;
   localparam logic [9:0] SKS_OFF_PKT_CNT = 10'h008;
   localparam logic [9:0] SKS_OFF_KEY_CNT = 10'h00C;
   localparam logic [9:0] SKS_OFF_DROP_CNT = 10'h010;
   localparam logic [9:0] SKS_OFF_PORT_TAG_BASE = 10'h040;
   localparam logic [9:0] SKS_OFF_PORT_TAG_LAST = 10'h05C;
   localparam logic [9:0] SKS_OFF_UDF_BASE = 10'h080;
   localparam logic [9:0] SKS_OFF_UDF_LAST = 10'h120;

   // Field positions
   localparam int SKS_CTRL_EN_BIT = 0;
   localparam int SKS_CTRL_SLICE_LSB = 1;
   localparam int SKS_UDF_EN_BIT = 4;
   localparam int SKS_STAT_BUSY_BIT = 0;
   localparam int SKS_STAT_SLICE_LSB = 1;
   localparam int SKS_STAT_EN_BIT = 3;

   // Values after reset
   localparam logic SKS_EN_RST = 1'b1;
   localparam logic [2:0] SKS_SLICE_EN_RST = 3'h7;
   localparam logic [31:0] SKS_PORT_TAG_RST = 32'h0001_0001;
   localparam logic [4:0] SKS_UDF_CFG_RST = 5'h00;
   localparam logic [31:0] SKS_CNT_RST = 32'h0000_0000;

   // Key encodings
   localparam logic [1:0] SKS_TAG_NONE = 2'h0;
   localparam logic [1:0] SKS_TAG_VID0 = 2'h1;
   localparam logic [1:0] SKS_TAG_VID = 2'h3;
   localparam logic [1:0] SKS_L2_ETH2 = 2'h0;
   localparam logic [1:0] SKS_L2_SNAP = 2'h1;
   localparam logic [1:0] SKS_L3_IPV6 = 2'h1;
   localparam logic [1:0] SKS_HOP_ZERO = 2'h0;
   localparam logic [1:0] SKS_HOP_ONE = 2'h1;
   localparam logic [1:0] SKS_HOP_OTHER = 2'h2;
   localparam logic [1:0] SKS_HOP_MAX = 2'h3;
   localparam logic [7:0] SKS_HOP_VAL_ZERO = 8'h00;
   localparam logic [7:0] SKS_HOP_VAL_ONE = 8'h01;
   localparam logic [7:0] SKS_HOP_VAL_MAX = 8'hFF;
   localparam logic [1:0] SKS_SLICE_VALID = 2'h3;
   localparam logic [7:0] SKS_PORT_ONE = 8'h01;

   typedef enum logic [1:0] {
      SKS_IDLE = 2'b01,
      SKS_EMIT = 2'b10
   } sks_fsm_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [9:0] addr;
      logic [31:0] wdata;
   } sks_reg_req_t;

   typedef struct packed {
      logic [2:0] ingress_port;
      logic outer_present;
      logic [15:0] outer_tag;
      logic inner_present;
      logic [15:0] inner_tag;
      logic snap;
      logic [7:0] ipv6_class_byte;
      logic [7:0] final_next_hdr;
      logic frag_flag;
      logic later_frag_flag;
      logic auth_hdr_flag;
      logic [7:0] hop_limit;
      logic [SKS_WIN-1:0][15:0] window;
      logic [4:0] window_len;
   } sks_pkt_t;

   typedef struct packed {
      logic [7:0] ingress_port_mask;
      logic [1:0] outer_tag_state;
      logic [1:0] inner_tag_state;
      logic [1:0] link_layer_encap_code;
      logic [1:0] network_layer_encap_code;
      logic [7:0] ipv6_class_byte;
      logic [7:0] final_next_hdr;
      logic frag_flag;
      logic later_frag_flag;
      logic auth_hdr_flag;
      logic [1:0] hop_limit_class;
      logic [1:0] rsvd_hop;
      logic [8:0] user_field_valid_vec;
      logic [15:0] outer_tag;
      logic [15:0] inner_tag;
      logic [8:0][15:0] ipv6_user_field;
      logic [3:0] rsvd_slice;
      logic [1:0] search_slice_sel;
      logic [1:0] slice_valid;
   } sks_key_t;

   typedef struct packed {
      logic enable;
      logic [2:0] slice_en;
      logic [SKS_PORTS-1:0][31:0] port_tags;
      logic [SKS_SLICES-1:0][SKS_UDFS-1:0][4:0] udf_cfg;
      logic [31:0] pkt_cnt;
      logic [31:0] key_cnt;
      logic [31:0] drop_cnt;
      logic [31:0] rdata;
      sks_fsm_t fsm;
      logic [1:0] slice;
      sks_pkt_t pkt;
      sks_key_t key;
   } sks_state_t;

endpackage

// file: test/sks_ipv6_key_chk.sv
`timescale 1ns/1ns
`default_nettype none
module sks_ipv6_key_chk
   import sks_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire sks_reg_req_t reg_req,
   input wire logic [31:0] reg_rdata,
   input wire logic pkt_ready,
   input wire sks_key_t key_out,
   input wire logic key_valid,
   input wire logic key_ready
);
   logic gate_ok;
   always_comb begin
      gate_ok = 1'b1;
      for (int f = 0; f < 9; f++) begin
         if (!key_out.user_field_valid_vec[f] && key_out.ipv6_user_field[f] != 16'h0000) begin
            gate_ok = 1'b0;
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);
   sequence s_wait;
      key_valid && !key_ready;
   endsequence
   sequence s_held;
      key_valid && $stable(key_out);
   endsequence
   a_key_held: assert property (s_wait |=> s_held)
      else $error("key changed before taken");
   a_busy_refuse: assert property (key_valid |-> !pkt_ready)
      else $error("packet offered while key pending");
   a_rsvd_zero: assert property (key_valid |->
      key_out.rsvd_hop == 2'h0 && key_out.rsvd_slice == 4'h0)
      else $error("reserved key bits set");
   a_slice_valid: assert property (key_valid |-> key_out.slice_valid == 2'h3)
      else $error("slice valid not both ones");
   a_l3_code: assert property (key_valid |-> key_out.network_layer_encap_code == 2'h1)
      else $error("network code not ipv6");
   a_slice_range: assert property (key_valid |-> key_out.search_slice_sel != 2'h3)
      else $error("slice selector out of range");
   a_port_onehot: assert property (key_valid |-> $onehot(key_out.ingress_port_mask))
      else $error("port map not one hot");
   a_later_frag: assert property (key_valid && key_out.later_frag_flag |-> key_out.frag_flag)
      else $error("later fragment without fragment");
   a_tag_codes: assert property (key_valid |->
      key_out.outer_tag_state != 2'h2 && key_out.inner_tag_state != 2'h2)
      else $error("reserved tag state");
   a_udf_gated: assert property (key_valid |-> gate_ok)
      else $error("invalid user field not zero");
   a_rdata_idle: assert property (!$past(reg_req.rd) |-> reg_rdata == 32'h0000_0000)
      else $error("read data outside answer cycle");
endmodule
`default_nettype wire

// file: test/sks_rule_sink.sv
`timescale 1ns/1ns
`default_nettype none
module sks_rule_sink
   import sks_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst_n,
   input wire logic [3:0] stall,
   input wire sks_key_t key_out,
   input wire logic key_valid,
   output logic key_ready,
   output logic got,
   output sks_key_t got_key
);
   logic [3:0] cnt;
   // Stall lets the bench hold a key for several cycles
   assign key_ready = key_valid && cnt >= stall;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 4'h0;
         got <= 1'b0;
         got_key <= '0;
      end else begin
         got <= key_valid && key_ready && key_out.slice_valid == 2'h3;
         if (key_valid && key_ready) begin
            cnt <= 4'h0;
            got_key <= key_out;
         end else if (key_valid) begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
   import sks_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   sks_reg_req_t reg_req = '0;
   logic [31:0] reg_rdata;
   sks_pkt_t pkt_in = '0;
   logic pkt_valid = 1'b0;
   logic pkt_ready, key_valid, key_ready, got;
   sks_key_t key_out, got_key;
   logic [3:0] stall = 4'h0;
   int errors = 0;
   int checked = 0;
   logic [31:0] ptag [8];
   logic [4:0] cfg [3][9];
   sks_ipv6_key sks_ipv6_key_i (.ref_clk(ref_clk), .rst_n(rst_n), .reg_req(reg_req),
      .reg_rdata(reg_rdata), .pkt_in(pkt_in), .pkt_valid(pkt_valid), .pkt_ready(pkt_ready),
      .key_out(key_out), .key_valid(key_valid), .key_ready(key_ready));
   sks_rule_sink sks_rule_sink_i (.ref_clk(ref_clk), .rst_n(rst_n), .stall(stall),
      .key_out(key_out), .key_valid(key_valid), .key_ready(key_ready), .got(got),
      .got_key(got_key));
   initial begin
      forever #4 ref_clk = ~ref_clk;
   end
   task automatic cmp(input logic [231:0] a, input logic [231:0] b);
      checked++;
      if (a !== b) begin
         errors++;
         $display("mismatch %0t value %h expected %h", $time, a, b);
      end
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk);
      reg_req <= '0;
   endtask
   task automatic rd(input logic [9:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      reg_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
      @(posedge ref_clk);
      reg_req <= '0;
      #1 cmp(232'(reg_rdata), 232'(e));
   endtask
   function automatic sks_key_t exp_key(input sks_pkt_t p, input int s);
      sks_key_t k;
      logic [31:0] t;
      logic [4:0] c;
      k = '0;
      t = ptag[p.ingress_port];
      k.ingress_port_mask = 8'h01 << p.ingress_port;
      k.outer_tag = p.outer_present ? p.outer_tag : t[31:16];
      k.inner_tag = p.inner_present ? p.inner_tag : t[15:0];
      k.outer_tag_state = !p.outer_present ? 2'h0 :
         (p.outer_tag[11:0] == 12'h000 ? 2'h1 : 2'h3);
      k.inner_tag_state = !p.inner_present ? 2'h0 :
         (p.inner_tag[11:0] == 12'h000 ? 2'h1 : 2'h3);
      k.link_layer_encap_code = {1'b0, p.snap};
      k.network_layer_encap_code = 2'h1;
      k.ipv6_class_byte = p.ipv6_class_byte;
      k.final_next_hdr = p.final_next_hdr;
      k.frag_flag = p.frag_flag;
      k.later_frag_flag = p.frag_flag & p.later_frag_flag;
      k.auth_hdr_flag = p.auth_hdr_flag;
      k.hop_limit_class = p.hop_limit == 8'h00 ? 2'h0 : p.hop_limit == 8'h01 ? 2'h1 :
         p.hop_limit == 8'hFF ? 2'h3 : 2'h2;
      for (int f = 0; f < 9; f++) begin
         c = cfg[s][f];
         if (c[4] && {1'b0, c[3:0]} < p.window_len) begin
            k.user_field_valid_vec[f] = 1'b1;
            k.ipv6_user_field[f] = p.window[c[3:0]];
         end
      end
      k.search_slice_sel = 2'(s);
      k.slice_valid = 2'h3;
      return k;
   endfunction
   task automatic send(input sks_pkt_t p, input logic [2:0] mask);
      int n;
      @(posedge ref_clk);
      pkt_in <= p;
      pkt_valid <= 1'b1;
      // Ready looked at while it stands, before the taking edge
      #1 cmp(232'(pkt_ready), 232'h0001);
      @(posedge ref_clk);
      pkt_valid <= 1'b0;
      for (int s = 0; s < 3; s++) begin
         if (mask[s]) begin
            n = 0;
            @(posedge ref_clk) #1;
            while (got !== 1'b1 && n < 60) begin
               @(posedge ref_clk) #1;
               n++;
            end
            if (got !== 1'b1) begin
               errors++;
               $display("mismatch %0t no key for slice %0d", $time, s);
            end
            cmp(got_key, exp_key(p, s));
         end
      end
      // No key beyond the enabled slices
      repeat (8) begin
         @(posedge ref_clk) #1;
         cmp(232'(got), 232'h0000);
      end
   endtask
   task automatic t_regs;
      rd(10'h000, 32'h0000_000F);
      rd(10'h040, 32'h0001_0001);
      rd(10'h3F0, 32'h0000_0000);
      cmp(232'($bits(key_out)), 232'h00E8);
   endtask
   task automatic t_slices;
      sks_pkt_t p;
      p = '0;
      wr(10'h08C, 32'h0000_0013);
      cfg[0][3] = 5'h13;
      wr(10'h0C0, 32'h0000_0012);
      cfg[1][0] = 5'h12;
      // Index past the window length must come out invalid
      wr(10'h120, 32'h0000_001F);
      cfg[2][8] = 5'h1F;
      p.ingress_port = 3'h3;
      p.outer_present = 1'b1;
      p.outer_tag = 16'hA005;
      p.inner_present = 1'b1;
      p.inner_tag = 16'h3000;
      p.snap = 1'b1;
      p.ipv6_class_byte = 8'hB4;
      p.final_next_hdr = 8'h2C;
      {p.frag_flag, p.later_frag_flag, p.auth_hdr_flag} = 3'h7;
      p.hop_limit = 8'hFF;
      for (int i = 0; i < 16; i++) begin
         p.window[i] = 16'h1000 + 16'(i);
      end
      p.window_len = 5'h04;
      stall <= 4'h3;
      send(p, 3'h7);
      stall <= 4'h0;
   endtask
   task automatic t_hops;
      sks_pkt_t p;
      logic [7:0] hops [4] = '{8'h00, 8'h01, 8'h07, 8'hFF};
      p = '0;
      wr(10'h000, 32'h0000_0009);
      wr(10'h05C, 32'h0123_4567);
      ptag[7] = 32'h0123_4567;
      p.ingress_port = 3'h7;
      p.later_frag_flag = 1'b1;
      foreach (hops[i]) begin
         p.hop_limit = hops[i];
         send(p, 3'h4);
      end
   endtask
   task automatic t_drop;
      sks_pkt_t p;
      p = '0;
      wr(10'h000, 32'h0000_0000);
      send(p, 3'h0);
      rd(10'h010, 32'h0000_0001);
      // One accepted packet in the slice test, four in the hop test
      rd(10'h008, 32'h0000_0005);
      rd(10'h00C, 32'h0000_0007);
      // Idle, last slice 2, disabled
      rd(10'h004, 32'h0000_0004);
      wr(10'h00C, 32'h0000_0000);
      rd(10'h00C, 32'h0000_0000);
      wr(10'h000, 32'h0000_000F);
   endtask
   task automatic print_verdict;
      if (errors == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      foreach (ptag[i]) begin
         ptag[i] = 32'h0001_0001;
      end
      foreach (cfg[s, f]) begin
         cfg[s][f] = 5'h00;
      end
      repeat (20) @(posedge ref_clk);
      rst_n <= 1'b1;
      t_regs();
      t_slices();
      t_hops();
      t_drop();
      print_verdict();
   end
   initial begin
      #40000;
      errors++;
      $display("mismatch %0t watchdog expired", $time);
      print_verdict();
   end
endmodule
bind sks_ipv6_key sks_ipv6_key_chk sks_ipv6_key_chk_i (.ref_clk(ref_clk), .rst_n(rst_n),
   .reg_req(reg_req), .reg_rdata(reg_rdata), .pkt_ready(pkt_ready), .key_out(key_out),
   .key_valid(key_valid), .key_ready(key_ready));
`default_nettype wire
